// *** core/limit_monitor.sv ***
// autonomous housekeeping limit monitor: sequencer, power actions and events
//
// Overview of operation
// - Check every housekeeping sample offered and act alone when it leaves its bounds.
// - Dangerous failures power the affected subunits off (all of them for own parameters); harmless ones only produce an event.
// - Own supply or temperature danger also requests a full suite shutdown from spacecraft.
// - Warning level reached without declared danger raises the warning event, with no power action.
// - Danger is declared only after two consecutive samples at or beyond danger level.
// - Own supply or temperature danger powers every subunit off before the danger event.
// - Each danger event carries the offending parameter code and its sampled level.
// - Ion analyser temperature danger powers only the ion analyser off, then the event.
// - Magnetometer reference danger powers only the magnetometer off, then the event.
// - Probe watchdog alarm powers the probe off and raises the watchdog event.
`timescale 1ns/10ps
module limit_monitor (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // housekeeping samples
  input wire logic i_sample_valid,
  input wire limit_pkg::index_type i_sample_index,
  input wire limit_pkg::level_type i_sample_level,
  output logic o_sample_ready,
  // probe watchdog alarm, level
  input wire logic i_probe_wdog_alarm,
  // subunit power
  input wire limit_pkg::unit_mask_type i_power_on,
  output limit_pkg::unit_mask_type o_power_en,
  // event packets
  output logic o_event_valid,
  output limit_pkg::code_type o_event_id,
  output limit_pkg::code_type o_event_code,
  output limit_pkg::level_type o_event_level,
  // suite shutdown request to the spacecraft
  output logic o_shutdown_req
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_OFF, ST_EMIT} state_type;

  state_type state_q;
  logic ready_q;
  logic ready_d;
  logic alarm_prev_q;
  logic wdog_rise;
  logic wdog_pend_q;
  logic wdog_pend_d;
  logic wdog_take;
  logic accept;
  logic res_quiet;
  logic next_idle;
  limit_pkg::unit_mask_type off_mask_q;
  limit_pkg::unit_mask_type off_req;
  logic shut_q;
  limit_pkg::code_type id_q;
  limit_pkg::code_type code_q;
  limit_pkg::level_type level_q;
  logic event_valid_q;
  logic shutdown_q;
  limit_pkg::class_type res_class;
  limit_pkg::code_type res_code;

  check_if chk ();

  assign accept = i_sample_valid && ready_q;
  assign chk.sample_valid = accept;
  assign chk.sample_index = i_sample_index;
  assign chk.sample_level = i_sample_level;

  limit_checker u_checker (
    .i_mclk (i_mclk),
    .i_reset (i_reset),
    .chk (chk.judge)
  );

  // indices beyond the table never raise danger, so their class is irrelevant
  assign res_class = (chk.res_index < limit_pkg::index_type'(limit_pkg::NUM_PARAMS)) ?
    limit_pkg::PARAM_CLASS[chk.res_index] : limit_pkg::CLASS_WARN_ONLY;
  assign res_code = (chk.res_index < limit_pkg::index_type'(limit_pkg::NUM_PARAMS)) ?
    limit_pkg::PARAM_CODE[chk.res_index] : limit_pkg::code_type'(chk.res_index);

  // watchdog alarm: input is synchronous, so a plain edge detect suffices
  assign wdog_rise = i_probe_wdog_alarm && !alarm_prev_q;
  assign wdog_take = (state_q == ST_IDLE) && wdog_pend_q;
  assign wdog_pend_d = wdog_rise || (wdog_pend_q && !wdog_take);

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      alarm_prev_q <= 1'b0;
    end else begin
      alarm_prev_q <= i_probe_wdog_alarm;
    end
  end

  // a new alarm arriving as the old one is taken stays pending
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wdog_pend_q <= 1'b0;
    end else begin
      wdog_pend_q <= wdog_pend_d;
    end
  end

  assign res_quiet = chk.res_valid && !chk.res_warn && !chk.res_danger;
  assign next_idle = (state_q == ST_IDLE && !wdog_take && !accept) ||
    (state_q == ST_WAIT && res_quiet) || (state_q == ST_EMIT);
  // one sample in flight at a time; a pending alarm holds off new samples
  assign ready_d = next_idle && !wdog_pend_d;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (wdog_take) begin
            state_q <= ST_OFF;
          end else if (accept) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (chk.res_valid && chk.res_danger) begin
            state_q <= ST_OFF;
          end else if (chk.res_valid && chk.res_warn) begin
            state_q <= ST_EMIT;
          end else if (chk.res_valid) begin
            state_q <= ST_IDLE;
          end
        end
        ST_OFF: state_q <= ST_EMIT;
        ST_EMIT: state_q <= ST_IDLE;
      endcase
    end
  end

  // latch what the pending event and power action will be
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      off_mask_q <= limit_pkg::NO_UNITS;
      shut_q <= 1'b0;
      id_q <= '0;
      code_q <= '0;
      level_q <= '0;
    end else if (wdog_take) begin
      off_mask_q <= limit_pkg::PROBE_MASK;
      shut_q <= 1'b0;
      id_q <= limit_pkg::PROBE_WATCHDOG_EVENT_ID;
      code_q <= limit_pkg::WATCHDOG_CODE;
      level_q <= limit_pkg::ZERO_LEVEL;
    end else if (state_q == ST_WAIT && chk.res_valid && (chk.res_warn || chk.res_danger)) begin
      off_mask_q <= chk.res_danger ? limit_pkg::class_mask(res_class) : limit_pkg::NO_UNITS;
      shut_q <= chk.res_danger && res_class == limit_pkg::CLASS_UNIT;
      id_q <= chk.res_danger ? limit_pkg::DANGER_EVENT_ID : limit_pkg::WARNING_EVENT_ID;
      code_q <= res_code;
      level_q <= chk.res_level;
    end
  end

  assign off_req = (state_q == ST_OFF) ? off_mask_q : limit_pkg::NO_UNITS;

  power_switch #(
    .UNITS (limit_pkg::NUM_UNITS)
  ) u_power (
    .i_mclk (i_mclk),
    .i_reset (i_reset),
    .i_on_req (i_power_on),
    .i_off_req (off_req),
    .o_power_en (o_power_en)
  );

  // the event leaves one cycle after the power enables have dropped
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      event_valid_q <= 1'b0;
      shutdown_q <= 1'b0;
    end else begin
      event_valid_q <= (state_q == ST_EMIT);
      shutdown_q <= (state_q == ST_EMIT) && shut_q;
    end
  end

  assign o_sample_ready = ready_q;
  assign o_event_valid = event_valid_q;
  assign o_event_id = id_q;
  assign o_event_code = code_q;
  assign o_event_level = level_q;
  assign o_shutdown_req = shutdown_q;

  chk_ready_only_idle: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_sample_ready |-> (state_q == ST_IDLE && !wdog_pend_q))
    else $error("sample ready outside idle");

  chk_off_applied: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_q == ST_OFF) |=> ((o_power_en & off_mask_q) == limit_pkg::NO_UNITS))
    else $error("offending units still powered after off step");

  chk_danger_after_off: assert property (@(posedge i_mclk) disable iff (i_reset)
    (chk.res_valid && chk.res_danger && state_q == ST_WAIT) |=>
      (state_q == ST_OFF) ##1 (state_q == ST_EMIT) ##1 (o_event_valid && o_event_id == limit_pkg::DANGER_EVENT_ID))
    else $error("danger event not preceded by power off step");

  chk_danger_fields: assert property (@(posedge i_mclk) disable iff (i_reset)
    (chk.res_valid && chk.res_danger && state_q == ST_WAIT) |-> ##3
      (o_event_code == $past(res_code, 3) && o_event_level == $past(chk.res_level, 3)))
    else $error("danger event carries wrong parameter or level");

  chk_warn_no_power: assert property (@(posedge i_mclk) disable iff (i_reset)
    (chk.res_valid && chk.res_warn && !chk.res_danger && state_q == ST_WAIT) |=>
      (off_mask_q == limit_pkg::NO_UNITS) ##1 (o_event_valid && o_event_id == limit_pkg::WARNING_EVENT_ID && !o_shutdown_req))
    else $error("warning event missing or caused power action");

  chk_ion_only_off: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_q == ST_WAIT && chk.res_danger && res_class == limit_pkg::CLASS_ION) |=> (off_mask_q == limit_pkg::ION_MASK))
    else $error("ion analyser danger switched the wrong units");

  chk_mag_only_off: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_q == ST_WAIT && chk.res_danger && res_class == limit_pkg::CLASS_MAGREF) |=> (off_mask_q == limit_pkg::MAG_MASK))
    else $error("magnetometer danger switched the wrong units");

  chk_unit_all_off: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_q == ST_WAIT && chk.res_danger && res_class == limit_pkg::CLASS_UNIT) |=>
      (off_mask_q == limit_pkg::ALL_UNITS && shut_q))
    else $error("own-parameter danger did not select all units");

  chk_shutdown_code: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_shutdown_req |-> (o_event_valid && o_event_id == limit_pkg::DANGER_EVENT_ID && limit_pkg::is_unit_code(o_event_code)))
    else $error("shutdown requested without own-parameter danger event");

  chk_wdog_event: assert property (@(posedge i_mclk) disable iff (i_reset)
    wdog_rise |-> ##[2:8] (o_event_valid && o_event_id == limit_pkg::PROBE_WATCHDOG_EVENT_ID))
    else $error("watchdog alarm not answered by its event");

  chk_wdog_probe_off: assert property (@(posedge i_mclk) disable iff (i_reset)
    (state_q == ST_OFF && id_q == limit_pkg::PROBE_WATCHDOG_EVENT_ID) |=> !o_power_en[limit_pkg::UNIT_PROBE])
    else $error("probe still powered after watchdog alarm");

  cov_danger_event: cover property (@(posedge i_mclk) disable iff (i_reset)
    o_event_valid && o_event_id == limit_pkg::DANGER_EVENT_ID);
  cov_warning_event: cover property (@(posedge i_mclk) disable iff (i_reset)
    o_event_valid && o_event_id == limit_pkg::WARNING_EVENT_ID);
  cov_wdog_event: cover property (@(posedge i_mclk) disable iff (i_reset)
    o_event_valid && o_event_id == limit_pkg::PROBE_WATCHDOG_EVENT_ID);
  cov_shutdown: cover property (@(posedge i_mclk) disable iff (i_reset) o_shutdown_req);

endmodule : limit_monitor

// *** include/limit_pkg.sv ***
// shared constants, types and decoders of the housekeeping limit monitor
package limit_pkg;

  localparam int NUM_PARAMS = 11;
  localparam int IDX_W = 4;
  localparam int LEVEL_W = 16;
  localparam int CODE_W = 16;
  localparam int NUM_UNITS = 5;
  localparam int DANGER_SAMPLES = 2;
  localparam int CNT_W = 2;

  typedef logic [LEVEL_W-1:0] level_type;
  typedef logic [CODE_W-1:0] code_type;
  typedef logic [IDX_W-1:0] index_type;
  typedef logic [NUM_UNITS-1:0] unit_mask_type;
  typedef logic [CNT_W-1:0] count_type;

  // what a danger on a parameter switches off
  typedef enum logic [1:0] {CLASS_UNIT, CLASS_ION, CLASS_MAGREF, CLASS_WARN_ONLY} class_type;

  // parameter slots in the sample index space
  localparam index_type IDX_POS5 = 4'h0;
  localparam index_type IDX_NEG5 = 4'h1;
  localparam index_type IDX_POS12 = 4'h2;
  localparam index_type IDX_NEG12 = 4'h3;
  localparam index_type IDX_28V = 4'h4;
  localparam index_type IDX_UNIT_TEMP = 4'h5;
  localparam index_type IDX_ION_TEMP_A = 4'h6;
  localparam index_type IDX_ION_TEMP_B = 4'h7;
  localparam index_type IDX_MAG_REF_A = 4'h8;
  localparam index_type IDX_MAG_REF_B = 4'h9;
  localparam index_type IDX_MAG_TEMP_DIFF = 4'ha;

  // power bit of each subunit
  localparam int UNIT_ION = 0;
  localparam int UNIT_ELECTRON = 1;
  localparam int UNIT_LANGMUIR = 2;
  localparam int UNIT_MAGNETO = 3;
  localparam int UNIT_PROBE = 4;
  localparam unit_mask_type NO_UNITS = 5'h00;
  localparam unit_mask_type ALL_UNITS = 5'h1f;
  localparam unit_mask_type ION_MASK = 5'h01;
  localparam unit_mask_type MAG_MASK = 5'h08;
  localparam unit_mask_type PROBE_MASK = 5'h10;
  localparam unit_mask_type POWER_RESET = 5'h00;

  localparam class_type PARAM_CLASS [NUM_PARAMS] = '{CLASS_UNIT, CLASS_UNIT, CLASS_UNIT, CLASS_UNIT,
    CLASS_UNIT, CLASS_UNIT, CLASS_ION, CLASS_ION, CLASS_MAGREF, CLASS_MAGREF, CLASS_WARN_ONLY};
  localparam code_type PARAM_CODE [NUM_PARAMS] = '{16'h0003, 16'h0006, 16'h0009, 16'h000b, 16'h000f,
    16'h0012, 16'h0020, 16'h0021, 16'h0030, 16'h0031, 16'h0032};

  // preset limits; a level at or beyond a bound counts as reached
  localparam level_type WARN_LO [NUM_PARAMS] = '{default: 16'h0400};
  localparam level_type WARN_HI [NUM_PARAMS] = '{default: 16'h0c00};
  localparam level_type DANGER_LO [NUM_PARAMS] = '{default: 16'h0200};
  localparam level_type DANGER_HI [NUM_PARAMS] = '{default: 16'h0e00};

  // event identifiers: values are arbitrary
  localparam code_type WARNING_EVENT_ID = 16'h0101;
  localparam code_type DANGER_EVENT_ID = 16'h0102;
  localparam code_type PROBE_WATCHDOG_EVENT_ID = 16'h0103;
  localparam code_type WATCHDOG_CODE = 16'h00ff;
  localparam level_type ZERO_LEVEL = 16'h0000;

  function automatic logic outside(input level_type v, input level_type lo, input level_type hi);
    return (v <= lo) || (v >= hi);
  endfunction : outside

  function automatic unit_mask_type class_mask(input class_type c);
    unit_mask_type m;
    m = NO_UNITS;
    unique case (c)
      CLASS_UNIT: m = ALL_UNITS;
      CLASS_ION: m = ION_MASK;
      CLASS_MAGREF: m = MAG_MASK;
      CLASS_WARN_ONLY: m = NO_UNITS;
    endcase
    return m;
  endfunction : class_mask

  function automatic logic is_unit_code(input code_type c);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_PARAMS; i++) begin
      if (PARAM_CLASS[i] == CLASS_UNIT && PARAM_CODE[i] == c) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : is_unit_code

endpackage : limit_pkg

// *** include/check_if.sv ***
// carrier between the sequencer and the limit checker
`timescale 1ns/10ps
interface check_if;
  logic sample_valid;
  limit_pkg::index_type sample_index;
  limit_pkg::level_type sample_level;
  logic res_valid;
  logic res_warn;
  logic res_danger;
  limit_pkg::index_type res_index;
  limit_pkg::level_type res_level;

  modport judge (input sample_valid, input sample_index, input sample_level,
    output res_valid, output res_warn, output res_danger, output res_index, output res_level);
  modport sequencer (output sample_valid, output sample_index, output sample_level,
    input res_valid, input res_warn, input res_danger, input res_index, input res_level);
endinterface : check_if

// *** core/power_switch.sv ***
// per-subunit power enables with command-on and monitor-off
`timescale 1ns/10ps
module power_switch #(
  parameter int UNITS = limit_pkg::NUM_UNITS
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // requests
  input wire logic [UNITS-1:0] i_on_req,
  input wire logic [UNITS-1:0] i_off_req,
  // enables
  output logic [UNITS-1:0] o_power_en
);

  genvar u;
  generate
    for (u = 0; u < UNITS; u++) begin : g_unit
      // off beats on: a unit being made safe must not come back in the same cycle
      always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
          o_power_en[u] <= limit_pkg::POWER_RESET[u];
        end else if (i_off_req[u]) begin
          o_power_en[u] <= 1'b0;
        end else if (i_on_req[u]) begin
          o_power_en[u] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule : power_switch

// *** core/limit_checker.sv ***
// limit comparison and consecutive-danger counting per parameter
`timescale 1ns/10ps
module limit_checker (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // samples in, verdicts out
  check_if.judge chk
);

  localparam int N = limit_pkg::NUM_PARAMS;

  limit_pkg::count_type count_q [N];
  logic in_range;
  logic beyond_danger;
  logic warn_hit;
  logic can_danger;
  limit_pkg::count_type cur_count;

  assign in_range = chk.sample_index < limit_pkg::index_type'(N);
  assign beyond_danger = in_range && limit_pkg::outside(chk.sample_level,
    limit_pkg::DANGER_LO[chk.sample_index], limit_pkg::DANGER_HI[chk.sample_index]);
  assign warn_hit = in_range && limit_pkg::outside(chk.sample_level,
    limit_pkg::WARN_LO[chk.sample_index], limit_pkg::WARN_HI[chk.sample_index]);
  assign can_danger = in_range && limit_pkg::PARAM_CLASS[chk.sample_index] != limit_pkg::CLASS_WARN_ONLY;
  assign cur_count = in_range ? count_q[chk.sample_index] : '0;

  genvar p;
  generate
    for (p = 0; p < N; p++) begin : g_count
      always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
          count_q[p] <= '0;
        end else if (chk.sample_valid && chk.sample_index == limit_pkg::index_type'(p)) begin
          if (!beyond_danger) begin
            count_q[p] <= '0;
          end else if (count_q[p] != limit_pkg::count_type'(limit_pkg::DANGER_SAMPLES)) begin
            count_q[p] <= count_q[p] + limit_pkg::count_type'(1);
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      chk.res_valid <= 1'b0;
      chk.res_warn <= 1'b0;
      chk.res_danger <= 1'b0;
      chk.res_index <= '0;
      chk.res_level <= '0;
    end else begin
      chk.res_valid <= chk.sample_valid;
      chk.res_warn <= chk.sample_valid && warn_hit;
      // this sample is the second or a later one in a row at danger level
      chk.res_danger <= chk.sample_valid && beyond_danger && can_danger &&
        (cur_count >= limit_pkg::count_type'(limit_pkg::DANGER_SAMPLES - 1));
      chk.res_index <= chk.sample_index;
      chk.res_level <= chk.sample_level;
    end
  end

  chk_first_danger_quiet: assert property (@(posedge i_mclk) disable iff (i_reset)
    (chk.sample_valid && beyond_danger && cur_count == '0) |=> !chk.res_danger)
    else $error("danger declared on first sample at danger level");
  chk_second_danger_fires: assert property (@(posedge i_mclk) disable iff (i_reset)
    (chk.sample_valid && beyond_danger && can_danger && cur_count == 2'h1) |=> chk.res_danger)
    else $error("danger missed on second consecutive sample");
  chk_warn_flagged: assert property (@(posedge i_mclk) disable iff (i_reset)
    (chk.sample_valid && warn_hit) |=> (chk.res_valid && chk.res_warn))
    else $error("warning level not flagged");

endmodule : limit_checker

// *** testbench/spacecraft_model.sv ***
// spacecraft side model: traps danger events and runs the suite shutdown procedure
`timescale 1ns/10ps
module spacecraft_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // event stream from the monitor
  input wire logic i_event_valid,
  input wire limit_pkg::code_type i_event_id,
  input wire limit_pkg::code_type i_event_code,
  input wire logic i_shutdown_req,
  // procedure outcome
  output logic [7:0] o_suite_off_count
);
  logic unit_code;
  // only the unit's own supplies and temperature lead to a shutdown
  assign unit_code = (i_event_code == 16'h0003) || (i_event_code == 16'h0006) || (i_event_code == 16'h0009) ||
    (i_event_code == 16'h000b) || (i_event_code == 16'h000f) || (i_event_code == 16'h0012);
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_suite_off_count <= 8'h00;
    end else if (i_event_valid && i_event_id == limit_pkg::DANGER_EVENT_ID && unit_code && i_shutdown_req) begin
      o_suite_off_count <= o_suite_off_count + 8'h01;
    end
  end
endmodule : spacecraft_model

// *** testbench/housekeeping_limit_monitor_test.sv ***
// self-checking bench of the housekeeping limit monitor
`timescale 1ns/10ps
module housekeeping_limit_monitor_test;
  logic i_mclk;
  logic i_reset;
  logic i_sample_valid;
  limit_pkg::index_type i_sample_index;
  limit_pkg::level_type i_sample_level;
  logic o_sample_ready;
  logic i_probe_wdog_alarm;
  limit_pkg::unit_mask_type i_power_on;
  limit_pkg::unit_mask_type o_power_en;
  logic o_event_valid;
  limit_pkg::code_type o_event_id;
  limit_pkg::code_type o_event_code;
  limit_pkg::level_type o_event_level;
  logic o_shutdown_req;
  logic [7:0] suite_off_count;
  int n_errors;
  int checks;
  logic [31:0] lfsr_q;
  int dcnt [11];
  int exp_off;
  limit_pkg::unit_mask_type exp_pwr;
  localparam logic [15:0] UNIT_CODES [6] = '{16'h0003, 16'h0006, 16'h0009, 16'h000b, 16'h000f, 16'h0012};
  // corner levels around both bands
  localparam logic [15:0] LEVELS [11] = '{16'h0000, 16'h0200, 16'h0201, 16'h0400, 16'h0401, 16'h0800,
    16'h0bff, 16'h0c00, 16'h0dff, 16'h0e00, 16'hffff};

  limit_monitor u_limit_monitor (.i_mclk(i_mclk), .i_reset(i_reset), .i_sample_valid(i_sample_valid),
    .i_sample_index(i_sample_index), .i_sample_level(i_sample_level), .o_sample_ready(o_sample_ready),
    .i_probe_wdog_alarm(i_probe_wdog_alarm), .i_power_on(i_power_on), .o_power_en(o_power_en),
    .o_event_valid(o_event_valid), .o_event_id(o_event_id), .o_event_code(o_event_code),
    .o_event_level(o_event_level), .o_shutdown_req(o_shutdown_req));
  spacecraft_model u_spacecraft_model (.i_mclk(i_mclk), .i_reset(i_reset), .i_event_valid(o_event_valid),
    .i_event_id(o_event_id), .i_event_code(o_event_code), .i_shutdown_req(o_shutdown_req),
    .o_suite_off_count(suite_off_count));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic beyond(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v <= lo) || (v >= hi);
  endfunction : beyond

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic pulse_power(input limit_pkg::unit_mask_type on);
    @(negedge i_mclk);
    i_power_on = on;
    @(negedge i_mclk);
    i_power_on = limit_pkg::NO_UNITS;
    exp_pwr = exp_pwr | on;
  endtask : pulse_power

  task automatic run_sample(input limit_pkg::index_type idx, input limit_pkg::level_type lvl);
    int k;
    int ev_n;
    int sd_n;
    logic [15:0] id;
    logic [15:0] code;
    logic [15:0] lv;
    limit_pkg::unit_mask_type pwr;
    logic warn;
    logic dang;
    limit_pkg::unit_mask_type off;
    logic [15:0] ecode;
    k = 0;
    while (o_sample_ready !== 1'b1 && k < 20) begin
      @(negedge i_mclk);
      k++;
    end
    check("ready", {31'h0, o_sample_ready}, 32'h1);
    i_sample_valid = 1'b1;
    i_sample_index = idx;
    i_sample_level = lvl;
    @(negedge i_mclk);
    i_sample_valid = 1'b0;
    ev_n = 0;
    sd_n = 0;
    for (k = 0; k < 6; k++) begin
      if (o_event_valid === 1'b1) begin
        ev_n++;
        id = o_event_id;
        code = o_event_code;
        lv = o_event_level;
        pwr = o_power_en;
      end
      if (o_shutdown_req === 1'b1) sd_n++;
      @(negedge i_mclk);
    end
    warn = 1'b0;
    dang = 1'b0;
    off = limit_pkg::NO_UNITS;
    ecode = 16'h0000;
    if (idx <= 10) begin
      ecode = (idx <= 5) ? UNIT_CODES[idx] : limit_pkg::PARAM_CODE[idx];
      warn = beyond(lvl, 16'h0400, 16'h0c00);
      // slot 10 has no danger limit; any in-limit sample clears its run
      if (beyond(lvl, 16'h0200, 16'h0e00) && idx != 10) dcnt[idx]++; else dcnt[idx] = 0;
      dang = dcnt[idx] >= 2;
    end
    if (dang) off = (idx <= 5) ? limit_pkg::ALL_UNITS : (idx <= 7) ? limit_pkg::ION_MASK : limit_pkg::MAG_MASK;
    exp_pwr = exp_pwr & ~off;
    check("event count", ev_n, (warn || dang) ? 1 : 0);
    if (warn || dang) begin
      check("event id", id, dang ? limit_pkg::DANGER_EVENT_ID : limit_pkg::WARNING_EVENT_ID);
      check("event code", code, ecode);
      check("event level", lv, lvl);
      check("power at event", pwr, exp_pwr);
    end
    check("shutdown count", sd_n, (dang && idx <= 5) ? 1 : 0);
    check("power after", o_power_en, exp_pwr);
    if (dang && idx <= 5) exp_off++;
    // follow a danger with an in-limit sample so the run restarts from zero
    if (dang) run_sample(idx, 16'h0800);
  endtask : run_sample

  task automatic run_alarm();
    int k;
    int ev_n;
    pulse_power(limit_pkg::PROBE_MASK);
    @(negedge i_mclk);
    i_probe_wdog_alarm = 1'b1;
    ev_n = 0;
    for (k = 0; k < 12; k++) begin
      @(negedge i_mclk);
      if (o_event_valid === 1'b1) begin
        ev_n++;
        check("alarm id", o_event_id, limit_pkg::PROBE_WATCHDOG_EVENT_ID);
        check("alarm code", o_event_code, limit_pkg::WATCHDOG_CODE);
        check("alarm level", o_event_level, limit_pkg::ZERO_LEVEL);
      end
    end
    exp_pwr = exp_pwr & ~limit_pkg::PROBE_MASK;
    check("alarm events", ev_n, 1);
    check("alarm power", o_power_en, exp_pwr);
    i_probe_wdog_alarm = 1'b0;
    @(negedge i_mclk);
  endtask : run_alarm

  task tally_and_finish();
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // about 200 samples of under 20 cycles each; far more than that means a hang
  initial begin
    repeat (40000) @(posedge i_mclk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    i_reset = 1'b1;
    i_sample_valid = 1'b0;
    i_sample_index = 4'h0;
    i_sample_level = 16'h0000;
    i_probe_wdog_alarm = 1'b0;
    i_power_on = limit_pkg::NO_UNITS;
    n_errors = 0;
    checks = 0;
    exp_off = 0;
    exp_pwr = limit_pkg::NO_UNITS;
    dcnt = '{default: 0};
    lfsr_q = 32'h27e0;
    repeat (16) @(negedge i_mclk);
    i_reset = 1'b0;
    check("power at reset", o_power_en, limit_pkg::POWER_RESET);
    pulse_power(limit_pkg::ALL_UNITS);
    run_sample(limit_pkg::IDX_POS5, 16'h0e00);
    run_sample(limit_pkg::IDX_POS5, 16'hffff);
    pulse_power(limit_pkg::ALL_UNITS);
    run_sample(limit_pkg::IDX_MAG_TEMP_DIFF, 16'h0000);
    run_sample(limit_pkg::IDX_MAG_TEMP_DIFF, 16'h0000);
    run_sample(limit_pkg::IDX_NEG12, 16'h0200);
    run_sample(limit_pkg::IDX_NEG12, 16'h0800);
    run_sample(limit_pkg::IDX_NEG12, 16'h0200);
    run_sample(limit_pkg::IDX_ION_TEMP_A, 16'h0e00);
    run_sample(limit_pkg::IDX_MAG_REF_B, 16'h0e00);
    run_sample(limit_pkg::IDX_ION_TEMP_A, 16'h0e00);
    run_sample(limit_pkg::IDX_MAG_REF_B, 16'h0000);
    run_alarm();
    for (int i = 0; i < 200; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      if (lfsr_q[3:0] == 4'h0) pulse_power(lfsr_q[8:4]);
      run_sample(limit_pkg::index_type'(lfsr_q[15:12] % 13), LEVELS[lfsr_q[23:20] % 11]);
      if (lfsr_q[31:27] == 5'h00) run_alarm();
    end
    check("suite shutdowns", suite_off_count, exp_off);
    tally_and_finish();
  end
endmodule : housekeeping_limit_monitor_test
